//--- qr_timing_pkg.sv
// constants for the quasi-resonant switch turn-on timing block
// assumes a 100 MHz core clock; all times counted in its cycles
package qr_timing_pkg;

  localparam int unsigned CLK_HZ           = 100_000_000;
  // maximum switching frequency, low and high variant
  localparam int unsigned FMAX_LOW_HZ      = 136_000;
  localparam int unsigned FMAX_HIGH_HZ     = 225_000;
  // oscillator period as longest time: rounds down
  localparam int unsigned OSC_LOW_CYC      = CLK_HZ / FMAX_LOW_HZ;
  localparam int unsigned OSC_HIGH_CYC     = CLK_HZ / FMAX_HIGH_HZ;
  // blanking times in ns (2.5 us and 6.3 us), least time: rounds up
  localparam int unsigned BLANK_SHORT_NS   = 2_500;
  localparam int unsigned BLANK_LONG_NS    = 6_300;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned BLANK_SHORT_CYC  =
    (BLANK_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_LONG_CYC   =
    (BLANK_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // valley delay after trigger, in ns
  localparam int unsigned VALLEY_DELAY_NS  = 200;
  localparam int unsigned VALLEY_DELAY_CYC =
    (VALLEY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // starter frequency default in Hz (parameter default of top)
  localparam int unsigned STARTER_HZ       = 20_000;

  localparam int unsigned CNT_W            = 16;

  typedef enum logic [2:0] {
    ST_STOPPED  = 3'b000,
    ST_CHARGE   = 3'b001,
    ST_ON       = 3'b010,
    ST_OFF      = 3'b011,
    ST_DELAY    = 3'b100,
    ST_BURST    = 3'b101
  } phase_t;

endpackage

//--- qr_down_counter.sv
// loadable down counter with done flag
// assumes single clock, asynchronous active-high reset
`timescale 1ns/1ps
module qr_down_counter (
  input  wire logic                            clk_i,
  input  wire logic                            reset_i,
  input  wire logic                            load_i,
  input  wire logic [qr_timing_pkg::CNT_W-1:0] value_i,
  output logic                                 done_o
);

  typedef struct packed {
    logic [qr_timing_pkg::CNT_W-1:0] count;
  } cnt_state_t;

  cnt_state_t state_reg;
  cnt_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (load_i) begin
      state_next.count = value_i;
    end else if (state_reg.count != '0) begin
      state_next.count = state_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign done_o = (state_reg.count == '0);

endmodule

//--- qr_switch_timing.sv
// turn-on timing for a quasi-resonant flyback power switch
// assumes all comparator inputs already synchronous to clk_i
//
// Contract
// - after a fault, stop; below restart level with drain ok, enable reduced charge; restart at on level.
// - in valley switching operation each turn-on follows a demag falling edge.
// - a falling edge below trigger threshold waits the valley delay, then turns on.
// - a trigger counts only after the detect input was first armed.
// - after each turn-off a blanking interval ignores trigger and arming, but an arm level still blocks starter entry.
// - a max-frequency oscillator restarts at each turn-on, 136 kHz or 225 kHz.
// - a valid trigger after a full oscillator period turns on and resyncs.
// - an early trigger is discarded and the circuit rearms, skipping valleys.
// - blanking not covered by the period extends the turn-on inhibit.
// - blanking is either 2.5 us short or 6.3 us long.
// - the strobe-sampled level above 1 V picks short blanking, else long.
// - no arm by the end of an oscillator period switches to starter mode.
// - once arming occurs the starter mode is left for demag locking.
// - at very light load switching pauses in burst operation.
// - supply below off threshold stops switching and inhibits start-up.
`timescale 1ns/1ps
module qr_switch_timing #(
  parameter bit          HIGH_VARIANT = 1'b0,
  parameter int unsigned STARTER_CYC  =
    qr_timing_pkg::CLK_HZ / qr_timing_pkg::STARTER_HZ
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic arm_above_i,
  input  wire logic trig_below_i,
  input  wire logic strobe_i,
  input  wire logic strobe_above_1v_i,
  input  wire logic switch_off_req_i,
  input  wire logic fault_i,
  input  wire logic burst_i,
  input  wire logic supply_on_i,
  input  wire logic supply_off_i,
  input  wire logic supply_restart_i,
  input  wire logic drain_start_ok_i,
  output logic      gate_o,
  output logic      reduced_charge_o,
  output logic      starter_mode_o,
  output logic      blank_short_o
);

  localparam int unsigned OSC_CYC = HIGH_VARIANT ?
    qr_timing_pkg::OSC_HIGH_CYC : qr_timing_pkg::OSC_LOW_CYC;

  typedef struct packed {
    qr_timing_pkg::phase_t   phase;
    logic                    armed;
    logic                    arm_seen;
    logic                    trig_prev;
    logic                    starter;
    logic                    faulted;
    logic                    blank_short;
    logic                    gate;
    logic                    charge;
    logic                    osc_load;
    logic                    blank_load;
    logic                    dly_load;
    logic                    st_load;
  } sw_state_t;

  sw_state_t state_reg;
  sw_state_t state_next;

  logic osc_done;
  logic blank_done;
  logic dly_done;
  logic st_done;
  logic trig_fall;

  //////////////////////////////////////////////////////////////////////////
  // timers

  qr_down_counter u_osc (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .load_i  (state_reg.osc_load),
    .value_i (qr_timing_pkg::CNT_W'(OSC_CYC)),
    .done_o  (osc_done)
  );

  qr_down_counter u_blank (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .load_i  (state_reg.blank_load),
    .value_i (state_reg.blank_short ?
              qr_timing_pkg::CNT_W'(qr_timing_pkg::BLANK_SHORT_CYC) :
              qr_timing_pkg::CNT_W'(qr_timing_pkg::BLANK_LONG_CYC)),
    .done_o  (blank_done)
  );

  qr_down_counter u_dly (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .load_i  (state_reg.dly_load),
    .value_i (qr_timing_pkg::CNT_W'(qr_timing_pkg::VALLEY_DELAY_CYC)),
    .done_o  (dly_done)
  );

  qr_down_counter u_st (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .load_i  (state_reg.st_load),
    .value_i (qr_timing_pkg::CNT_W'(STARTER_CYC)),
    .done_o  (st_done)
  );

  // comparator inputs are used directly as synchronous bits
  assign trig_fall = trig_below_i & ~state_reg.trig_prev;

  //////////////////////////////////////////////////////////////////////////
  // control

  always_comb begin
    state_next            = state_reg;
    state_next.trig_prev  = trig_below_i;
    state_next.osc_load   = 1'b0;
    state_next.blank_load = 1'b0;
    state_next.dly_load   = 1'b0;
    state_next.st_load    = 1'b0;

    if (strobe_i) begin
      state_next.blank_short = strobe_above_1v_i;
    end

    case (state_reg.phase)
      qr_timing_pkg::ST_STOPPED: begin
        state_next.gate = 1'b0;
        if (supply_restart_i && drain_start_ok_i && state_reg.faulted) begin
          state_next.charge = 1'b1;
          state_next.phase  = qr_timing_pkg::ST_CHARGE;
        end else if (!state_reg.faulted && supply_on_i) begin
          state_next.phase  = qr_timing_pkg::ST_CHARGE;
        end
      end
      qr_timing_pkg::ST_CHARGE: begin
        if (supply_on_i) begin
          state_next.charge   = 1'b0;
          state_next.faulted  = 1'b0;
          state_next.starter  = 1'b1;
          state_next.gate     = 1'b1;
          state_next.osc_load = 1'b1;
          state_next.phase    = qr_timing_pkg::ST_ON;
        end
      end
      qr_timing_pkg::ST_ON: begin
        if (switch_off_req_i) begin
          state_next.gate       = 1'b0;
          state_next.blank_load = 1'b1;
          state_next.armed      = 1'b0;
          state_next.arm_seen   = 1'b0;
          state_next.st_load    = 1'b1;
          state_next.phase      = qr_timing_pkg::ST_OFF;
        end
      end
      qr_timing_pkg::ST_OFF: begin
        // level reached counts even while blanking hides the edge
        if (arm_above_i) begin
          state_next.arm_seen = 1'b1;
        end
        if (blank_done && !state_reg.blank_load) begin
          if (arm_above_i) begin
            state_next.armed   = 1'b1;
            state_next.starter = 1'b0;
          end
          if (trig_fall && state_reg.armed) begin
            state_next.armed = 1'b0;
            // inhibit holds until both period and blanking are over
            if (osc_done && !state_reg.osc_load) begin
              state_next.dly_load = 1'b1;
              state_next.phase    = qr_timing_pkg::ST_DELAY;
            end
          end
        end
        if (osc_done && !state_reg.osc_load && !state_reg.arm_seen &&
            !arm_above_i) begin
          state_next.starter = 1'b1;
        end
        if (state_reg.starter && st_done && !state_reg.st_load) begin
          state_next.gate     = 1'b1;
          state_next.osc_load = 1'b1;
          state_next.phase    = qr_timing_pkg::ST_ON;
        end
        if (burst_i) begin
          state_next.phase = qr_timing_pkg::ST_BURST;
        end
      end
      qr_timing_pkg::ST_DELAY: begin
        if (dly_done && !state_reg.dly_load) begin
          state_next.gate     = 1'b1;
          state_next.osc_load = 1'b1;
          state_next.phase    = qr_timing_pkg::ST_ON;
        end
      end
      qr_timing_pkg::ST_BURST: begin
        state_next.armed    = 1'b0;
        state_next.arm_seen = 1'b0;
        if (!burst_i) begin
          state_next.st_load = 1'b1;
          state_next.phase   = qr_timing_pkg::ST_OFF;
        end
      end
      default: begin
        state_next.phase = qr_timing_pkg::ST_STOPPED;
      end
    endcase

    if (fault_i || supply_off_i) begin
      state_next.gate   = 1'b0;
      state_next.charge = 1'b0;
      state_next.phase  = qr_timing_pkg::ST_STOPPED;
    end
    // a new fault wins over the clear on restart
    if (fault_i) begin
      state_next.faulted = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '{phase:       qr_timing_pkg::ST_STOPPED,
                     armed:       1'b0,
                     arm_seen:    1'b0,
                     trig_prev:   1'b1,
                     starter:     1'b1,
                     faulted:     1'b0,
                     blank_short: 1'b0,
                     gate:        1'b0,
                     charge:      1'b0,
                     osc_load:    1'b0,
                     blank_load:  1'b0,
                     dly_load:    1'b0,
                     st_load:     1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign gate_o           = state_reg.gate;
  assign reduced_charge_o = state_reg.charge;
  assign starter_mode_o   = state_reg.starter;
  assign blank_short_o    = state_reg.blank_short;

endmodule

//--- qr_switch_timing_props.sv
// assertions on the switch timing block ports
// assumes one 100 MHz clock and async active-high reset
`timescale 1ns/1ps
module qr_switch_timing_props #(
  parameter bit          HIGH_VARIANT = 1'b0,
  parameter int unsigned STARTER_CYC  = 5000
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic arm_above_i,
  input wire logic trig_below_i,
  input wire logic strobe_i,
  input wire logic strobe_above_1v_i,
  input wire logic switch_off_req_i,
  input wire logic fault_i,
  input wire logic burst_i,
  input wire logic supply_on_i,
  input wire logic supply_off_i,
  input wire logic supply_restart_i,
  input wire logic drain_start_ok_i,
  input wire logic gate_o,
  input wire logic reduced_charge_o,
  input wire logic starter_mode_o,
  input wire logic blank_short_o
);
  localparam int unsigned OSC = HIGH_VARIANT ?
    qr_timing_pkg::OSC_HIGH_CYC : qr_timing_pkg::OSC_LOW_CYC;
  int unsigned off_cnt;
  int unsigned on_cnt;
  int unsigned trg_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////
  // cycles since turn-off, turn-on and last trigger
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i) off_cnt <= 0;
    else off_cnt <= gate_o ? 0 : off_cnt + 1;
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i) on_cnt <= 0;
    else on_cnt <= $rose(gate_o) ? 0 : on_cnt + 1;
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i) trg_cnt <= 0;
    else trg_cnt <= $rose(trig_below_i) ? 0 : trg_cnt + 1;
  ////////////////////////////////////////////////////////////////////
  a_fault_stops: assert property (fault_i |=> !gate_o)
    else $error("gate stayed on after fault");
  a_charge_gate_off: assert property (reduced_charge_o |-> !gate_o)
    else $error("gate on while recharging");
  a_charge_cause: assert property ($rose(reduced_charge_o) |->
    $past(supply_restart_i) && $past(drain_start_ok_i))
    else $error("recharge without restart level");
  a_valley_delay: assert property ($rose(gate_o) &&
    !$past(starter_mode_o) |-> trg_cnt inside {[18:26]})
    else $error("turn-on not one valley delay after trigger");
  a_blank_hold: assert property ($rose(gate_o) &&
    !$past(starter_mode_o) |-> off_cnt >= (blank_short_o ? 250 : 630))
    else $error("turn-on inside blanking");
  a_osc_period: assert property ($rose(gate_o) &&
    !$past(starter_mode_o) |-> on_cnt + 1 >= OSC)
    else $error("turn-on before oscillator period");
  a_strobe_pick: assert property (strobe_i |=>
    blank_short_o == $past(strobe_above_1v_i))
    else $error("blanking choice not from strobe sample");
  a_burst_pause: assert property ($past(burst_i, 2) &&
    $past(burst_i) && burst_i |-> !$rose(gate_o))
    else $error("turn-on during burst pause");
  a_supply_off: assert property (supply_off_i |=> !gate_o)
    else $error("gate on below off threshold");
  c_valley_on: cover property ($rose(gate_o) && !starter_mode_o);
  c_recharge: cover property ($rose(reduced_charge_o));
  c_starter_exit: cover property ($fell(starter_mode_o));
endmodule

bind qr_switch_timing qr_switch_timing_props #(
  .HIGH_VARIANT(HIGH_VARIANT),
  .STARTER_CYC (STARTER_CYC)
) props (
  .clk_i             (clk_i),
  .reset_i           (reset_i),
  .arm_above_i       (arm_above_i),
  .trig_below_i      (trig_below_i),
  .strobe_i          (strobe_i),
  .strobe_above_1v_i (strobe_above_1v_i),
  .switch_off_req_i  (switch_off_req_i),
  .fault_i           (fault_i),
  .burst_i           (burst_i),
  .supply_on_i       (supply_on_i),
  .supply_off_i      (supply_off_i),
  .supply_restart_i  (supply_restart_i),
  .drain_start_ok_i  (drain_start_ok_i),
  .gate_o            (gate_o),
  .reduced_charge_o  (reduced_charge_o),
  .starter_mode_o    (starter_mode_o),
  .blank_short_o     (blank_short_o)
);

//--- aux_winding_model.sv
// auxiliary winding seen through the arm and trigger comparators
// assumes gate_i from the switch block, same clock as the block
`timescale 1ns/1ps
module aux_winding_model #(
  parameter int unsigned DEMAG_CYC = 300,
  parameter int unsigned HALF_CYC  = 40
) (
  input  wire logic clk_i,
  input  wire logic ring_en_i,
  input  wire logic gate_i,
  output logic      arm_above_o,
  output logic      trig_below_o
);
  int unsigned t = 0;
  initial arm_above_o = 1'b0;
  initial trig_below_o = 1'b1;
  // plateau arms, then ringing alternates arm and trigger
  always @(posedge clk_i) begin
    if (gate_i || !ring_en_i) begin
      t <= 0;
      arm_above_o <= 1'b0;
      trig_below_o <= 1'b1;
    end else begin
      t <= t + 1;
      arm_above_o <= t < DEMAG_CYC ||
        ((t - DEMAG_CYC) / HALF_CYC) % 2 == 1;
      trig_below_o <= t >= DEMAG_CYC &&
        ((t - DEMAG_CYC) / HALF_CYC) % 2 == 0;
    end
  end
endmodule

//--- qr_switch_timing_tb.sv
// self-checking bench for the switch timing block
// assumes the winding model drives the detect comparator bits
`timescale 1ns/1ps
module qr_switch_timing_tb;
  localparam int OSC = qr_timing_pkg::OSC_LOW_CYC;
  // starter period longer than long blanking plus first ring arm
  localparam int ST_CYC = 1000;
  logic clk_i = 0, reset_i = 1, strobe_i = 0, strobe_above_1v_i = 0;
  logic switch_off_req_i = 0, fault_i = 0, burst_i = 0, supply_on_i = 1;
  logic supply_off_i = 0, supply_restart_i = 0, drain_start_ok_i = 0;
  logic arm_above_i, trig_below_i, ring_en = 0;
  logic gate_o, reduced_charge_o, starter_mode_o, blank_short_o;
  int   err_total = 0, n_tests = 0, on_t = 0, n;
  qr_switch_timing #(.HIGH_VARIANT(1'b0), .STARTER_CYC(ST_CYC)) dut (
    .clk_i             (clk_i),
    .reset_i           (reset_i),
    .arm_above_i       (arm_above_i),
    .trig_below_i      (trig_below_i),
    .strobe_i          (strobe_i),
    .strobe_above_1v_i (strobe_above_1v_i),
    .switch_off_req_i  (switch_off_req_i),
    .fault_i           (fault_i),
    .burst_i           (burst_i),
    .supply_on_i       (supply_on_i),
    .supply_off_i      (supply_off_i),
    .supply_restart_i  (supply_restart_i),
    .drain_start_ok_i  (drain_start_ok_i),
    .gate_o            (gate_o),
    .reduced_charge_o  (reduced_charge_o),
    .starter_mode_o    (starter_mode_o),
    .blank_short_o     (blank_short_o));
  aux_winding_model wind (.clk_i(clk_i), .ring_en_i(ring_en),
    .gate_i(gate_o), .arm_above_o(arm_above_i),
    .trig_below_o(trig_below_i));
  initial forever #5 clk_i = ~clk_i;
  // on-time of 100 cycles ended by the turn-off request
  always @(posedge clk_i) begin
    on_t <= gate_o ? on_t + 1 : 0;
    switch_off_req_i <= gate_o && on_t >= 98;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // cycles until the gate has gone low and risen again
  task automatic next_rise(output int c);
    c = 0;
    while (gate_o !== 1'b0 && c < 3000) begin cyc(1); c++; end
    while (gate_o !== 1'b1 && c < 3000) begin cyc(1); c++; end
    if (c >= 3000) chk(1'b0, "gate edge timeout");
  endtask
  task automatic t_starter();
    next_rise(n);
    next_rise(n);
    chk(n >= ST_CYC && n < ST_CYC + 200 && starter_mode_o === 1'b1,
      "starter not running");
  endtask
  task automatic t_valley();
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk_i) strobe_above_1v_i <= s[0];
      strobe_i <= 1'b1;
      @(posedge clk_i) strobe_i <= 1'b0;
      cyc(1);
      chk(blank_short_o === s[0], "blanking choice");
      @(posedge clk_i) ring_en <= 1'b1;
      next_rise(n);
      next_rise(n);
      chk(starter_mode_o === 1'b0, "starter not left");
      next_rise(n);
      chk(n >= OSC && n < OSC + 200, "valley period");
    end
  endtask
  task automatic t_burst();
    @(posedge clk_i) burst_i <= 1'b1;
    ring_en <= 1'b0;
    cyc(200);
    n = 0;
    repeat (2000) begin cyc(1); n += gate_o; end
    chk(n == 0, "switching in burst pause");
    @(posedge clk_i) burst_i <= 1'b0;
    next_rise(n);
    chk(n < 3000, "no resume after burst");
  endtask
  task automatic t_fault();
    @(posedge clk_i) fault_i <= 1'b1;
    supply_on_i <= 1'b0;
    @(posedge clk_i) fault_i <= 1'b0;
    cyc(20);
    chk(gate_o === 1'b0 && reduced_charge_o === 1'b0, "fault stop");
    @(posedge clk_i) supply_restart_i <= 1'b1;
    drain_start_ok_i <= 1'b1;
    cyc(4);
    chk(reduced_charge_o === 1'b1, "no recharge");
    @(posedge clk_i) supply_restart_i <= 1'b0;
    supply_on_i <= 1'b1;
    n = 0;
    while (gate_o !== 1'b1 && n < 10) begin cyc(1); n++; end
    chk(n < 10 && reduced_charge_o === 1'b0, "no restart");
  endtask
  task automatic t_off();
    @(posedge clk_i) supply_off_i <= 1'b1;
    supply_on_i <= 1'b0;
    cyc(2);
    n = 0;
    repeat (1000) begin cyc(1); n += gate_o; end
    chk(n == 0, "switching below off level");
  endtask
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    chk(gate_o === 1'b0 && reduced_charge_o === 1'b0 &&
      starter_mode_o === 1'b1 && blank_short_o === 1'b0, "reset values");
    @(posedge clk_i) reset_i <= 1'b0;
    t_starter();
    t_valley();
    t_burst();
    t_fault();
    t_off();
    summarize();
  end
  initial begin
    #500_000;
    err_total++;
    summarize();
  end
endmodule
